/* rtl/erc_pkg.sv */
package erc_pkg;
	// Register offsets of the plain register port
	localparam logic [3:0] ADDR_SETUP = 4'h0;
	localparam logic [3:0] ADDR_EXC_A = 4'h1;
	localparam logic [3:0] ADDR_EXC_B = 4'h2;
	localparam logic [3:0] ADDR_CTRL = 4'h3;
	localparam logic [3:0] ADDR_STATUS = 4'h4;
	localparam logic [3:0] ADDR_RESULT = 4'h5;
	localparam logic [3:0] ADDR_RAW = 4'h6;

	// Field positions
	localparam int DELAY_LSB = 0;
	localparam int ROT_BIT = 4;
	localparam int PIN_LSB = 0;
	localparam int MAG_LSB = 4;
	localparam int RUN_BIT = 0;
	localparam int REF_BIT = 1;

	// Pin and magnitude codes
	localparam int PIN_COUNT = 11;
	localparam logic [3:0] PIN_OFF = 4'hf;
	localparam logic [3:0] MAG_COUNT = 4'ha;
	localparam logic [3:0] MAG_OFF = 4'h0;

	// Reset values
	localparam logic [4:0] SETUP_RST = 5'h00;
	localparam logic [7:0] EXC_RST = 8'h0f;

	// Settling times in ns, counts at 100 MHz
	localparam int CLK_NS = 10;
	localparam int SETTLE_NS = 1000;
	localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
	localparam int STEP_NS = 500;
	localparam int STEP_CYC = (STEP_NS + CLK_NS - 1) / CLK_NS;

	typedef enum logic [1:0] {
		ERC_IDLE = 2'b00,
		ERC_SETTLE = 2'b01,
		ERC_CONVERT = 2'b11
	} erc_state_e;

	typedef struct packed {
		logic [3:0] mag;
		logic [3:0] pin;
	} erc_source_s;
endpackage

/* rtl/erc_pair_avg.sv */
`timescale 1ns/1ps
module erc_pair_avg #(
	parameter int WIDTH = 32
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// Control
	input wire logic restart,
	input wire logic rotate,
	// Conversion in
	input wire logic sample_valid,
	input wire logic [WIDTH-1:0] sample,
	// Result out
	output logic result_valid,
	output logic [WIDTH-1:0] result
);
	logic [WIDTH-1:0] prev;
	logic have_prev;
	logic [WIDTH:0] sum;

	// Sign-extended sum keeps the carry so the halving cannot overflow; the dropped LSB rounds down
	assign sum = {sample[WIDTH-1], sample} + {prev[WIDTH-1], prev};

	always_ff @(posedge clk_sys) begin
		if (!rst_b || restart) begin
			have_prev <= 1'b0;
		end else if (sample_valid) begin
			have_prev <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			prev <= '0;
		end else if (sample_valid) begin
			prev <= sample;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			result_valid <= 1'b0;
			result <= '0;
		end else begin
			result_valid <= 1'b0;
			if (sample_valid && !restart) begin
				if (!rotate) begin
					result_valid <= 1'b1;
					result <= sample;
				end else if (have_prev) begin
					result_valid <= 1'b1; // R5
					result <= sum[WIDTH:1]; // R6
				end
			end
		end
	end
endmodule

/* rtl/erc_top.sv */
// Chosen here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
// How it works
// R1 - Two independent sources, each routed to one of eleven analog pins, or to none for pin codes 11 to 15.
// R2 - Each source takes one of ten magnitude codes, 50 uA up to 3000 uA.
// R3 - Software enables the internal reference before using the sources.
// R4 - Rotation mode swaps source pins on every other conversion.
// R5 - First rotation-mode conversion is withheld; output starts after the second.
// R6 - Each later rotation output is newest plus previous conversion, halved.
// R7 - A built-in settling wait follows each pin swap before converting.
// R8 - Four-bit delay field adds extra settling time, lowering output rate in rotation mode.
// R9 - Added delay leaves the decimation filter untouched.
// R10 - Host may instead rotate pins itself and average in software.
// R11 - Restart or newly enabled rotation begins at normal positions, withholding again.
module erc_top #(
	parameter int WIDTH = 32,
	parameter int SETTLE_CYCLES = erc_pkg::SETTLE_CYC,
	parameter int STEP_CYCLES = erc_pkg::STEP_CYC
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [31:0] reg_rdata,
	// Converter core
	output logic conv_start,
	input wire logic conv_done,
	input wire logic [WIDTH-1:0] conv_data,
	// Analog switch controls
	output logic [erc_pkg::PIN_COUNT-1:0] excitation_source_a_sel,
	output logic [erc_pkg::PIN_COUNT-1:0] excitation_source_b_sel,
	output logic [3:0] excitation_source_a_mag,
	output logic [3:0] excitation_source_b_mag,
	output logic ref_enable,
	// Results
	output logic result_valid,
	output logic [WIDTH-1:0] result
);
	////////////////////////////////////////////////////////////////////////////////
	// Registers
	logic [4:0] setup;
	erc_pkg::erc_source_s src_a;
	erc_pkg::erc_source_s src_b;
	logic run;
	logic [WIDTH-1:0] raw;
	logic swapped;
	logic busy;
	erc_pkg::erc_state_e state;
	logic [15:0] wait_cnt;
	logic rot;
	logic rot_d;
	logic restart;
	logic run_d;

	// Out-of-range codes park the source rather than guess a pin or current
	function automatic logic [erc_pkg::PIN_COUNT-1:0] pin_onehot(input logic [3:0] p);
		logic [erc_pkg::PIN_COUNT-1:0] v;
		v = '0;
		if (p < 4'(erc_pkg::PIN_COUNT)) begin
			v[p] = 1'b1;
		end
		return v;
	endfunction

	function automatic logic [3:0] mag_clip(input logic [3:0] m);
		return (m < erc_pkg::MAG_COUNT) ? m : erc_pkg::MAG_OFF;
	endfunction

	assign rot = setup[erc_pkg::ROT_BIT];

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			setup <= erc_pkg::SETUP_RST;
			src_a <= erc_pkg::EXC_RST;
			src_b <= erc_pkg::EXC_RST;
			run <= 1'b0;
		end else if (reg_write) begin
			unique case (reg_addr)
				erc_pkg::ADDR_SETUP: setup <= reg_wdata[4:0];
				erc_pkg::ADDR_EXC_A: src_a <= reg_wdata[7:0];
				erc_pkg::ADDR_EXC_B: src_b <= reg_wdata[7:0];
				erc_pkg::ADDR_CTRL: begin
					run <= reg_wdata[erc_pkg::RUN_BIT];
				end
				default: ;
			endcase
		end
	end

	// Sources only work once software turns the reference on; this bit just gates that
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			ref_enable <= 1'b0;
		end else if (reg_write && reg_addr == erc_pkg::ADDR_CTRL) begin
			ref_enable <= reg_wdata[erc_pkg::REF_BIT]; // R3
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			reg_rdata <= '0;
		end else begin
			reg_rdata <= '0;
			if (reg_read) begin
				unique case (reg_addr)
					erc_pkg::ADDR_SETUP: reg_rdata <= {27'h0, setup};
					erc_pkg::ADDR_EXC_A: reg_rdata <= {24'h0, src_a};
					erc_pkg::ADDR_EXC_B: reg_rdata <= {24'h0, src_b};
					erc_pkg::ADDR_CTRL: reg_rdata <= {30'h0, ref_enable, run};
					erc_pkg::ADDR_STATUS: reg_rdata <= {29'h0, busy, swapped, rot};
					erc_pkg::ADDR_RESULT: reg_rdata <= 32'(result);
					erc_pkg::ADDR_RAW: reg_rdata <= 32'(raw);
					default: reg_rdata <= '0;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Sequencer
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			rot_d <= 1'b0;
			run_d <= 1'b0;
		end else begin
			rot_d <= rot;
			run_d <= run;
		end
	end

	// Edges only, so a held run or rotate bit does not restart every cycle
	assign restart = (run && !run_d) || (rot && !rot_d); // R11
	assign busy = (state != erc_pkg::ERC_IDLE);

	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			state <= erc_pkg::ERC_IDLE;
			wait_cnt <= '0;
			conv_start <= 1'b0;
			swapped <= 1'b0;
		end else begin
			conv_start <= 1'b0;
			if (!run || restart) begin
				state <= erc_pkg::ERC_IDLE;
				swapped <= 1'b0; // R11
			end else begin
				unique case (state)
					erc_pkg::ERC_IDLE: begin
						state <= erc_pkg::ERC_SETTLE;
						// Delay only lengthens the gap; filter timing is not touched
						wait_cnt <= 16'(SETTLE_CYCLES + STEP_CYCLES * setup[3:0]); // R7 R8 R9
					end
					erc_pkg::ERC_SETTLE: begin
						if (wait_cnt <= 16'h0001) begin
							state <= erc_pkg::ERC_CONVERT;
							conv_start <= 1'b1;
						end else begin
							wait_cnt <= wait_cnt - 16'h0001;
						end
					end
					erc_pkg::ERC_CONVERT: begin
						if (conv_done) begin
							if (rot) begin
								swapped <= !swapped; // R4
								state <= erc_pkg::ERC_IDLE;
							end else begin
								// No swap, so no settling wait
								swapped <= 1'b0;
								conv_start <= 1'b1;
							end
						end
					end
					default: begin
						state <= erc_pkg::ERC_IDLE;
					end
				endcase
			end
		end
	end

	// Raw word kept for hosts that rotate and average in software
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			raw <= '0;
		end else if (conv_done) begin
			raw <= conv_data;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pin routing
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			excitation_source_a_sel <= '0;
			excitation_source_b_sel <= '0;
			excitation_source_a_mag <= erc_pkg::MAG_OFF;
			excitation_source_b_mag <= erc_pkg::MAG_OFF;
		end else begin
			// Swap moves the pins only; each magnitude stays with its own source
			excitation_source_a_sel <= pin_onehot(swapped ? src_b.pin : src_a.pin); // R1 R4
			excitation_source_b_sel <= pin_onehot(swapped ? src_a.pin : src_b.pin); // R1 R4
			excitation_source_a_mag <= mag_clip(src_a.mag); // R2
			excitation_source_b_mag <= mag_clip(src_b.mag); // R2
		end
	end

	// Withholding and pairing restart whenever the sequencer does
	erc_pair_avg #(
		.WIDTH(WIDTH)
	) u_avg (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.restart(restart || !run),
		.rotate(rot),
		.sample_valid(conv_done && state == erc_pkg::ERC_CONVERT),
		.sample(conv_data),
		.result_valid(result_valid),
		.result(result)
	);
endmodule

/* sim/erc_core_model.sv */
`timescale 1ns/1ps
module erc_core_model (
	// Clock
	input wire logic clk_sys,
	// Handshake
	input wire logic conv_start,
	input wire logic slow,
	output logic conv_done,
	output logic [31:0] conv_data
);
	int cnt = 0;
	logic [31:0] idx = 32'h0;
	initial conv_done = 1'b0;
	initial conv_data = 32'h0;
	always @(posedge clk_sys) begin
		conv_done <= 1'b0;
		// Data toggles when not valid, never holds
		conv_data <= ~conv_data;
		if (conv_start)
			cnt <= slow ? 20 : 3;
		else if (cnt > 0)
			cnt <= cnt - 1;
		if (!conv_start && cnt == 1) begin
			conv_done <= 1'b1;
			conv_data <= idx * 32'h101 - 32'h303;
			idx <= idx + 32'h1;
		end
	end
endmodule

/* sim/erc_top_props.sv */
`timescale 1ns/1ps
module erc_top_props (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic reg_write,
	// Converter and outputs
	input wire logic conv_start,
	input wire logic conv_done,
	input wire logic [10:0] excitation_source_a_sel,
	input wire logic [10:0] excitation_source_b_sel,
	input wire logic [3:0] excitation_source_a_mag,
	input wire logic [3:0] excitation_source_b_mag,
	input wire logic ref_enable,
	input wire logic result_valid
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	////////////////////////////////////////////////////////////////
	sequence s_swap;
		$changed(excitation_source_a_sel) && excitation_source_a_sel != 0 && $past(conv_done, 2);
	endsequence
	property p_sel_a; $onehot0(excitation_source_a_sel); endproperty
	a_sel_a: assert property (p_sel_a) else $error("source a select not one-hot");
	property p_sel_b; $onehot0(excitation_source_b_sel); endproperty
	a_sel_b: assert property (p_sel_b) else $error("source b select not one-hot");
	property p_mag_a; excitation_source_a_mag < 4'ha; endproperty
	a_mag_a: assert property (p_mag_a) else $error("source a magnitude out of range");
	property p_mag_b; excitation_source_b_mag < 4'ha; endproperty
	a_mag_b: assert property (p_mag_b) else $error("source b magnitude out of range");
	property p_ref; $changed(ref_enable) |-> $past(reg_write) && $past(reg_addr) == erc_pkg::ADDR_CTRL; endproperty
	a_ref: assert property (p_ref) else $error("reference enable moved without control write");
	property p_swap;
		s_swap |-> excitation_source_a_sel == $past(excitation_source_b_sel)
			&& excitation_source_b_sel == $past(excitation_source_a_sel);
	endproperty
	a_swap: assert property (p_swap) else $error("pin swap not an exchange");
	property p_result; result_valid |-> $past(conv_done); endproperty
	a_result: assert property (p_result) else $error("result without finished conversion");
	property p_settle; s_swap |-> !conv_start [*2]; endproperty
	a_settle: assert property (p_settle) else $error("conversion started without settling");
	c_result: cover property (result_valid);
	c_swap: cover property (s_swap);
	c_ref: cover property ($rose(ref_enable));
endmodule
bind erc_top erc_top_props erc_top_props_inst (.clk_sys, .rst_b, .reg_addr, .reg_write, .conv_start,
	.conv_done, .excitation_source_a_sel, .excitation_source_b_sel, .excitation_source_a_mag,
	.excitation_source_b_mag, .ref_enable, .result_valid);

/* sim/tb.sv */
`timescale 1ns/1ps
module tb;
	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic slow = 1'b0;
	logic rot = 1'b0;
	logic [31:0] reg_rdata, conv_data, result, cur, prev;
	logic conv_start, conv_done, result_valid, ref_enable;
	logic [10:0] sel_a, sel_b;
	logic [3:0] mag_a, mag_b;
	int n_fail = 0;
	int comparisons = 0;
	int nd = 0;
	int gap = 0;
	localparam int SET_CYC = 2;
	localparam int STP_CYC = 1;
	initial forever #5 clk_sys = ~clk_sys;
	erc_top #(.SETTLE_CYCLES(SET_CYC), .STEP_CYCLES(STP_CYC)) erc_top_inst (.clk_sys, .rst_b, .reg_addr, .reg_wdata,
		.reg_write, .reg_read, .reg_rdata, .conv_start, .conv_done, .conv_data, .excitation_source_a_sel(sel_a),
		.excitation_source_b_sel(sel_b), .excitation_source_a_mag(mag_a), .excitation_source_b_mag(mag_b),
		.ref_enable, .result_valid, .result);
	erc_core_model erc_core_model_inst (.clk_sys, .conv_start, .slow, .conv_done, .conv_data);
	////////////////////////////////////////////////////////////////
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clk_sys);
		reg_write <= 1'b0;
		repeat (2) @(posedge clk_sys);
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] exp);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk_sys);
		reg_read <= 1'b0;
		@(negedge clk_sys);
		chk("reg_rdata", exp, reg_rdata);
		@(posedge clk_sys);
	endtask
	task automatic wait_res(input int need);
		int i;
		logic [32:0] s;
		// Leave the launching edge first, so a pulse from the last call is not taken again
		@(negedge clk_sys);
		for (i = 0; i < 300 && result_valid !== 1'b1; i++)
			@(negedge clk_sys);
		if (i == 300) begin
			n_fail++;
			report_and_stop();
		end
		s = {cur[31], cur} + {prev[31], prev};
		chk("result", rot ? s[32:1] : cur, result);
		chk("conversions", need, nd);
		@(posedge clk_sys);
	endtask
	// Lets a stray conversion land before counting anew
	task automatic stop;
		int i;
		wr(erc_pkg::ADDR_CTRL, 32'h0);
		for (i = 0; i < 50 && erc_core_model_inst.cnt != 0; i++)
			@(posedge clk_sys);
		if (i == 50)
			n_fail++;
		// One more edge so a last pulse and the routing settle before counting anew
		@(posedge clk_sys);
		nd = 0;
	endtask
	always @(posedge clk_sys) begin
		if (conv_done) begin
			prev <= cur;
			cur <= conv_data;
			nd <= nd + 1;
		end
		gap <= conv_done ? 1 : gap + 1;
		if (conv_start && rot && nd == 1)
			chk("swapped sel a", 32'h400, sel_a);
		// Idle edge, settle count with delay field 1, start edge
		if (conv_start && rot && nd > 0)
			chk("settle gap", 32'(SET_CYC + STP_CYC * 1 + 2), gap);
	end
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (4) @(posedge clk_sys);
		rst_b <= 1'b1;
		@(posedge clk_sys);
		rd(erc_pkg::ADDR_EXC_A, 32'h0f);
		rd(erc_pkg::ADDR_SETUP, 32'h0);
		rd(4'hf, 32'h0);
		wr(erc_pkg::ADDR_EXC_B, 32'ha0);
		chk("mag b", 32'h0, mag_b);
		wr(erc_pkg::ADDR_EXC_A, 32'h92);
		wr(erc_pkg::ADDR_EXC_B, 32'h0a);
		chk("sel a", 32'h4, sel_a);
		chk("mag a", 32'h9, mag_a);
		chk("sel b", 32'h400, sel_b);
		wr(erc_pkg::ADDR_CTRL, 32'h3);
		chk("ref", 32'h1, ref_enable);
		wait_res(1);
		wait_res(2);
		stop();
		rot = 1'b1;
		slow <= 1'b1;
		wr(erc_pkg::ADDR_SETUP, 32'h11);
		wr(erc_pkg::ADDR_CTRL, 32'h3);
		wait_res(2);
		wait_res(3);
		stop();
		chk("sel a restarted", 32'h4, sel_a);
		rd(erc_pkg::ADDR_STATUS, 32'h1);
		slow <= 1'b0;
		wr(erc_pkg::ADDR_CTRL, 32'h3);
		wait_res(2);
		stop();
		wr(erc_pkg::ADDR_EXC_A, 32'h9a);
		wr(erc_pkg::ADDR_EXC_B, 32'h02);
		chk("manual sel a", 32'h400, sel_a);
		chk("manual sel b", 32'h4, sel_b);
		report_and_stop();
	end
endmodule
